/* File: src/sce_pkg.sv */
// Constants shared by the socket command and event block
package sce_pkg;

  // Command codes
  localparam logic [7:0] CMD_OPEN      = 8'h01;
  localparam logic [7:0] CMD_LISTEN    = 8'h02;
  localparam logic [7:0] CMD_CONNECT   = 8'h04;
  localparam logic [7:0] CMD_TEARDOWN  = 8'h08;
  localparam logic [7:0] CMD_CLOSE     = 8'h10;
  localparam logic [7:0] CMD_SEND      = 8'h20;
  localparam logic [7:0] CMD_SEND_FHW  = 8'h21;
  localparam logic [7:0] CMD_KEEPALIVE = 8'h22;
  localparam logic [7:0] CMD_PPP_START = 8'h23;
  localparam logic [7:0] CMD_PPP_STOP  = 8'h24;
  localparam logic [7:0] CMD_PPP_REQ   = 8'h25;
  localparam logic [7:0] CMD_PPP_NAK   = 8'h26;
  localparam logic [7:0] CMD_PPP_REJ   = 8'h27;
  localparam logic [7:0] CMD_RECEIVE_DONE_COMMAND      = 8'h40;

  // Protocol mode codes
  localparam logic [3:0] MODE_CLOSED = 4'h0;
  localparam logic [3:0] MODE_TCP    = 4'h1;
  localparam logic [3:0] MODE_UDP    = 4'h2;
  localparam logic [3:0] MODE_IPRAW  = 4'h3;
  localparam logic [3:0] MODE_MACRAW = 4'h4;
  localparam logic [3:0] MODE_PPPOE  = 4'h5;

  // Socket state codes as read by the host
  localparam logic [7:0] SS_RELEASED   = 8'h00;
  localparam logic [7:0] SS_INIT       = 8'h13;
  localparam logic [7:0] SS_LISTEN     = 8'h14;
  localparam logic [7:0] SS_CONNECTING = 8'h15;
  localparam logic [7:0] SS_LINKED     = 8'h17;
  localparam logic [7:0] SS_CLOSING    = 8'h18;
  localparam logic [7:0] SS_CLOSE_WAIT = 8'h1c;
  localparam logic [7:0] SS_UDP        = 8'h22;
  localparam logic [7:0] SS_IPRAW      = 8'h32;
  localparam logic [7:0] SS_MACRAW     = 8'h42;
  localparam logic [7:0] SS_PPPOE      = 8'h5f;

  // Event flag register
  localparam logic [15:0] REG_EVENT_FLAGS  = 16'h4002;
  localparam logic [7:0]  EVENT_FLAGS_RST  = 8'h00;
  localparam int          EV_ESTABLISHED   = 0;
  localparam int          EV_FIN_RX        = 1;
  localparam int          EV_DATA_RX       = 2;
  localparam int          EV_TIMEOUT       = 3;
  localparam int          EV_SEND_DONE     = 4;
  localparam int          EV_PPP_PHASE     = 5;
  localparam int          EV_PPP_AUTH_FAIL = 6;
  localparam int          EV_PPP_UNSUP     = 7;

  // Transmit request kinds
  localparam logic [3:0] PK_FIN       = 4'h1;
  localparam logic [3:0] PK_DATA      = 4'h2;
  localparam logic [3:0] PK_DATA_FHW  = 4'h3;
  localparam logic [3:0] PK_KEEPALIVE = 4'h4;
  localparam logic [3:0] PK_PPP_DISC  = 4'h5;
  localparam logic [3:0] PK_PPP_TERM  = 4'h6;
  localparam logic [3:0] PK_PPP_REQ   = 4'h7;
  localparam logic [3:0] PK_PPP_NAK   = 4'h8;
  localparam logic [3:0] PK_PPP_REJ   = 4'h9;

  // Transmit request field layout
  localparam int PTR_W      = 16;
  localparam int REQ_W      = 4 + 2 * PTR_W;
  localparam int KIND_LSB   = 2 * PTR_W;
  localparam int RDPTR_LSB  = PTR_W;
  localparam int WRPTR_LSB  = 0;
  localparam int KEEP_BYTES = 1;

  typedef enum logic [3:0] {
    ST_CLOSED     = 4'b0000,
    ST_INIT       = 4'b0001,
    ST_CONNECTING = 4'b0011,
    ST_LINKED     = 4'b0010,
    ST_CLOSING    = 4'b0110,
    ST_CLOSE_WAIT = 4'b0111,
    ST_LISTEN     = 4'b0101,
    ST_UDP        = 4'b0100,
    ST_IPRAW      = 4'b1100,
    ST_MACRAW     = 4'b1101,
    ST_PPPOE      = 4'b1111
  } sce_state_t;

endpackage

/* File: src/sce_stream_if.sv */
// Valid/ready stream carrying transmit requests
interface sce_stream_if #(
  parameter int W = 36
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* File: src/sce_buf2.sv */
// Two-entry valid/ready buffer
module sce_buf2
  import sce_pkg::*;
(
  input  wire logic  clk_sys,
  input  wire logic  rst,
  sce_stream_if.snk  in_s,
  sce_stream_if.src  out_s
);
  localparam int W = $bits(in_s.data);

  logic [W-1:0] mem_q [2];
  logic         wr_q;
  logic         rd_q;
  logic [1:0]   cnt_q;
  logic         push;
  logic         pop;

  assign in_s.ready  = (cnt_q != 2'd2);
  assign out_s.valid = (cnt_q != 2'd0);
  assign out_s.data  = mem_q[rd_q];
  assign push        = in_s.valid & in_s.ready;
  assign pop         = out_s.valid & out_s.ready;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      cnt_q <= 2'd0;
    end else begin
      if (push) wr_q <= ~wr_q;
      if (pop) rd_q <= ~rd_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) mem_q[wr_q] <= in_s.data;
  end
endmodule

/* File: src/sce_socket_ctrl.sv */
// Socket command interpreter, state and event flags

module sce_socket_ctrl
  import sce_pkg::*;
#(
  parameter int SOCKET_ID = 0
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             cmd_valid,
  input  wire logic [7:0]       cmd_code,
  output wire logic             cmd_ready,
  output logic                  cmd_ignored_q,
  input  wire logic [3:0]       socket_protocol_mode,
  input  wire logic [7:0]       socket_event_mask,
  input  wire logic             flags_wr,
  input  wire logic [7:0]       flags_wdata,
  output logic [7:0]            socket_event_flags_q,
  output wire logic             global_socket_flag,
  output logic [7:0]            socket_state_q,
  input  wire logic [PTR_W-1:0] tx_read_pointer,
  input  wire logic [PTR_W-1:0] tx_write_pointer,
  input  wire logic [PTR_W-1:0] rx_read_pointer,
  output logic                  rx_consume_q,
  output logic [PTR_W-1:0]      rx_consumed_ptr_q,
  output wire logic             txq_valid,
  input  wire logic             txq_ready,
  output wire logic [3:0]       txq_kind,
  output wire logic [PTR_W-1:0] txq_rd_ptr,
  output wire logic [PTR_W-1:0] txq_wr_ptr,
  input  wire logic             ev_established,
  input  wire logic             ev_fin_rx,
  input  wire logic             ev_finack_rx,
  input  wire logic             ev_rst_rx,
  input  wire logic             ev_data_rx,
  input  wire logic             ev_timeout,
  input  wire logic             ev_send_done,
  input  wire logic             ev_ppp_unsup,
  input  wire logic             ev_ppp_auth_fail,
  input  wire logic             ev_ppp_phase
);

  sce_state_t st_q;
  sce_state_t st_d;

  sce_stream_if #(.W(REQ_W)) push_s ();
  sce_stream_if #(.W(REQ_W)) pop_s ();

  sce_buf2 u_buf (
    .clk_sys (clk_sys),
    .rst     (rst),
    .in_s    (push_s),
    .out_s   (pop_s)
  );

  // Mode and state qualifiers
  wire is_tcp   = (socket_protocol_mode == MODE_TCP);
  wire is_udp   = (socket_protocol_mode == MODE_UDP);
  wire ppp_ok   = (SOCKET_ID == 0) &&
                  (socket_protocol_mode == MODE_PPPOE);
  wire tcp_conn = (st_q == ST_CONNECTING) || (st_q == ST_LISTEN);
  wire tcp_live = (st_q == ST_LINKED) || (st_q == ST_CLOSE_WAIT);
  wire tcp_any  = tcp_conn || tcp_live || (st_q == ST_INIT) ||
                  (st_q == ST_CLOSING);
  wire dgram    = (st_q == ST_UDP) || (st_q == ST_IPRAW) ||
                  (st_q == ST_MACRAW);

  // Command taken only while the buffer has room
  assign cmd_ready = push_s.ready;
  wire take = cmd_valid & cmd_ready;

  // Command decode
  wire c_open  = take && (cmd_code == CMD_OPEN) && (st_q == ST_CLOSED) &&
                 (socket_protocol_mode != MODE_CLOSED);
  wire c_lstn  = take && (cmd_code == CMD_LISTEN) && is_tcp &&
                 (st_q == ST_INIT);
  wire c_conn  = take && (cmd_code == CMD_CONNECT) && is_tcp &&
                 (st_q == ST_INIT);
  wire c_tdown = take && (cmd_code == CMD_TEARDOWN) && is_tcp && tcp_live;
  wire c_close = take && (cmd_code == CMD_CLOSE);
  wire c_send  = take && (cmd_code == CMD_SEND) &&
                 ((is_tcp && tcp_live) || dgram);
  wire c_fhw   = take && (cmd_code == CMD_SEND_FHW) && is_udp &&
                 (st_q == ST_UDP);
  wire c_keep  = take && (cmd_code == CMD_KEEPALIVE) && is_tcp &&
                 (st_q == ST_LINKED);
  wire c_receive_done_command  = take && (cmd_code == CMD_RECEIVE_DONE_COMMAND) &&
                 ((is_tcp && tcp_live) || dgram);
  wire c_pstart = take && (cmd_code == CMD_PPP_START) && ppp_ok;
  wire c_pstop  = take && (cmd_code == CMD_PPP_STOP) && ppp_ok;
  wire c_preq   = take && (cmd_code == CMD_PPP_REQ) && ppp_ok;
  wire c_pnak   = take && (cmd_code == CMD_PPP_NAK) && ppp_ok;
  wire c_prej   = take && (cmd_code == CMD_PPP_REJ) && ppp_ok;

  wire c_known = c_open | c_lstn | c_conn | c_tdown | c_close |
                 c_send | c_fhw | c_keep | c_receive_done_command | c_pstart |
                 c_pstop | c_preq | c_pnak | c_prej;

  // Transmit request kind
  wire [3:0] req_kind =
      c_tdown  ? PK_FIN       :
      c_send   ? PK_DATA      :
      c_fhw    ? PK_DATA_FHW  :
      c_keep   ? PK_KEEPALIVE :
      c_pstart ? PK_PPP_DISC  :
      c_pstop  ? PK_PPP_TERM  :
      c_preq   ? PK_PPP_REQ   :
      c_pnak   ? PK_PPP_NAK   :
      c_prej   ? PK_PPP_REJ   :
                 4'h0;

  // Keep-alive carries a single byte past the read pointer
  wire [PTR_W-1:0] keep_end = tx_read_pointer + PTR_W'(KEEP_BYTES);
  wire [PTR_W-1:0] req_wr   = c_keep ? keep_end : tx_write_pointer;

  assign push_s.valid = take && (req_kind != 4'h0);
  assign push_s.data  = {req_kind, tx_read_pointer, req_wr};

  assign pop_s.ready = txq_ready;
  assign txq_valid   = pop_s.valid;
  assign txq_kind    = pop_s.data[KIND_LSB +: 4];
  assign txq_rd_ptr  = pop_s.data[RDPTR_LSB +: PTR_W];
  assign txq_wr_ptr  = pop_s.data[WRPTR_LSB +: PTR_W];

  // State opened by the protocol mode
  wire sce_state_t open_st =
      (socket_protocol_mode == MODE_TCP)    ? ST_INIT   :
      (socket_protocol_mode == MODE_UDP)    ? ST_UDP    :
      (socket_protocol_mode == MODE_IPRAW)  ? ST_IPRAW  :
      (socket_protocol_mode == MODE_MACRAW) ? ST_MACRAW :
      ((socket_protocol_mode == MODE_PPPOE) && (SOCKET_ID == 0)) ?
                                              ST_PPPOE  : ST_CLOSED;

  // Socket state machine
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_CLOSED: begin
        if (c_open) st_d = open_st;
      end
      ST_INIT: begin
        if (c_lstn) st_d = ST_LISTEN;
        else if (c_conn) st_d = ST_CONNECTING;
      end
      ST_CONNECTING, ST_LISTEN: begin
        if (ev_timeout) st_d = ST_CLOSED;
        else if (ev_established) st_d = ST_LINKED;
      end
      ST_LINKED: begin
        if (c_tdown) st_d = ST_CLOSING;
        else if (ev_timeout) st_d = ST_CLOSED;
        else if (ev_fin_rx) st_d = ST_CLOSE_WAIT;
      end
      ST_CLOSE_WAIT: begin
        if (c_tdown) st_d = ST_CLOSING;
        else if (ev_timeout) st_d = ST_CLOSED;
      end
      ST_CLOSING: begin
        if (ev_finack_rx) st_d = ST_CLOSED;
        else if (ev_timeout) st_d = ST_CLOSED;
      end
      ST_PPPOE: begin
        if (c_pstop) st_d = ST_CLOSED;
      end
      default: st_d = st_q;
    endcase
    if (ev_rst_rx && tcp_any) st_d = ST_CLOSED;
    if (c_close) st_d = ST_CLOSED;
  end

  // Host-visible state code
  wire [7:0] state_code =
      (st_d == ST_INIT)       ? SS_INIT       :
      (st_d == ST_LISTEN)     ? SS_LISTEN     :
      (st_d == ST_CONNECTING) ? SS_CONNECTING :
      (st_d == ST_LINKED)     ? SS_LINKED     :
      (st_d == ST_CLOSING)    ? SS_CLOSING    :
      (st_d == ST_CLOSE_WAIT) ? SS_CLOSE_WAIT :
      (st_d == ST_UDP)        ? SS_UDP        :
      (st_d == ST_IPRAW)      ? SS_IPRAW      :
      (st_d == ST_MACRAW)     ? SS_MACRAW     :
      (st_d == ST_PPPOE)      ? SS_PPPOE      :
                                SS_RELEASED;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q           <= ST_CLOSED;
      socket_state_q <= SS_RELEASED;
    end else begin
      st_q           <= st_d;
      socket_state_q <= state_code;
    end
  end

  // Raw events per flag bit
  logic [7:0] ev_raw;
  always_comb begin
    ev_raw                   = 8'h00;
    ev_raw[EV_ESTABLISHED]   = ev_established & tcp_conn;
    ev_raw[EV_FIN_RX]        = ev_fin_rx & (st_q == ST_LINKED);
    ev_raw[EV_DATA_RX]       = ev_data_rx;
    ev_raw[EV_TIMEOUT]       = ev_timeout;
    ev_raw[EV_SEND_DONE]     = ev_send_done;
    ev_raw[EV_PPP_PHASE]     = ev_ppp_phase & ppp_ok;
    ev_raw[EV_PPP_AUTH_FAIL] = ev_ppp_auth_fail & ppp_ok;
    ev_raw[EV_PPP_UNSUP]     = ev_ppp_unsup & ppp_ok;
  end

  wire [7:0] ev_set = ev_raw & socket_event_mask;
  wire [7:0] ev_clr = flags_wr ? flags_wdata : 8'h00;

  // Sticky flags, a set beats a clear in the same cycle
  genvar b;
  generate
    for (b = 0; b < 8; b++) begin : g_flag
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          socket_event_flags_q[b] <= EVENT_FLAGS_RST[b];
        end else if (ev_set[b]) begin
          socket_event_flags_q[b] <= 1'b1;
        end else if (ev_clr[b]) begin
          socket_event_flags_q[b] <= 1'b0;
        end
      end
    end
  endgenerate

  assign global_socket_flag = |socket_event_flags_q;

  // Receive consumption and ignored-command report
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_consume_q      <= 1'b0;
      rx_consumed_ptr_q <= '0;
      cmd_ignored_q     <= 1'b0;
    end else begin
      rx_consume_q  <= c_receive_done_command;
      cmd_ignored_q <= take & ~c_known;
      if (c_receive_done_command) rx_consumed_ptr_q <= rx_read_pointer;
    end
  end

endmodule

/* File: testbench/sce_drain_model.sv */
// Protocol engine stand-in that drains the transmit queue
module sce_drain_model
  import sce_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             stall,
  input  wire logic             txq_valid,
  input  wire logic [3:0]       txq_kind,
  input  wire logic [PTR_W-1:0] txq_rd_ptr,
  input  wire logic [PTR_W-1:0] txq_wr_ptr,
  output wire logic             txq_ready,
  output logic      [7:0]       kind_log,
  output logic      [PTR_W-1:0] span
);
  timeunit 1ns;
  timeprecision 1ns;
  // Ready withheld while stalling
  assign txq_ready = !stall;
  // Records kind and byte span of each popped request
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      kind_log <= 8'h00;
      span     <= '0;
    end else if (txq_valid && txq_ready) begin
      kind_log <= {kind_log[3:0], txq_kind};
      span     <= txq_wr_ptr - txq_rd_ptr;
    end
  end
endmodule

/* File: testbench/sce_socket_ctrl_sva.sv */
// Concurrent checks on the socket command block ports
module sce_socket_ctrl_sva
  import sce_pkg::*;
#(
  parameter int SOCKET_ID = 0
) (
  input wire logic             clk_sys,
  input wire logic             rst,
  input wire logic             cmd_valid,
  input wire logic [7:0]       cmd_code,
  input wire logic             cmd_ready,
  input wire logic [3:0]       socket_protocol_mode,
  input wire logic [7:0]       socket_event_mask,
  input wire logic             flags_wr,
  input wire logic [7:0]       flags_wdata,
  input wire logic [7:0]       socket_event_flags_q,
  input wire logic             global_socket_flag,
  input wire logic [7:0]       socket_state_q,
  input wire logic [PTR_W-1:0] rx_read_pointer,
  input wire logic             rx_consume_q,
  input wire logic [PTR_W-1:0] rx_consumed_ptr_q,
  input wire logic             txq_valid,
  input wire logic             txq_ready,
  input wire logic [3:0]       txq_kind,
  input wire logic             ev_finack_rx,
  input wire logic             ev_rst_rx,
  input wire logic             ev_data_rx,
  input wire logic             ev_timeout
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence s_taken(c);
    cmd_valid && cmd_ready && cmd_code == c;
  endsequence

  a_send_push: assert property (
    s_taken(CMD_SEND) ##0 (socket_state_q == SS_LINKED && !txq_valid)
    |=> txq_valid && txq_kind == PK_DATA)
    else $error("send did not queue a data request");
  a_receive_done_command_ptr: assert property (
    s_taken(CMD_RECEIVE_DONE_COMMAND) ##0 (socket_state_q == SS_LINKED)
    |=> rx_consume_q && rx_consumed_ptr_q == $past(rx_read_pointer))
    else $error("receive pointer not consumed");
  a_close_cmd: assert property (
    s_taken(CMD_CLOSE) ##0 !txq_valid
    |=> socket_state_q == SS_RELEASED && !txq_valid)
    else $error("close did not release quietly");
  a_rst_close: assert property (
    ev_rst_rx && socket_protocol_mode == MODE_TCP && !cmd_valid
    |=> socket_state_q == SS_RELEASED)
    else $error("reset segment left socket open");
  a_finack_close: assert property (
    ev_finack_rx && socket_state_q == SS_CLOSING
    |=> socket_state_q == SS_RELEASED)
    else $error("fin ack did not release socket");
  a_timeout_close: assert property (
    ev_timeout && socket_event_mask[3] && socket_state_q == SS_CLOSING
    |=> socket_event_flags_q[3] && socket_state_q == SS_RELEASED)
    else $error("teardown timeout mishandled");
  a_timeout_bit: assert property (
    ev_timeout && socket_event_mask[3] |=> socket_event_flags_q[3])
    else $error("timeout flag not set");
  a_mask_gate: assert property (
    $rose(socket_event_flags_q[2])
    |-> $past(ev_data_rx) && $past(socket_event_mask[2]))
    else $error("receive flag set without masked event");
  a_clear_one: assert property (
    flags_wr && flags_wdata[2] && !ev_data_rx |=> !socket_event_flags_q[2])
    else $error("write one did not clear");
  a_keep_zero: assert property (
    flags_wr && !flags_wdata[2] && socket_event_flags_q[2]
    |=> socket_event_flags_q[2])
    else $error("write zero cleared a flag");
  a_global_or: assert property (
    global_socket_flag == (|socket_event_flags_q))
    else $error("global flag differs from flag summary");
  a_ppp_gate: assert property (
    $rose(socket_event_flags_q[7])
    |-> SOCKET_ID == 0 && $past(socket_protocol_mode) == MODE_PPPOE)
    else $error("ppp flag outside ppp mode");
  a_txq_hold: assert property (
    txq_valid && !txq_ready |=> txq_valid && $stable(txq_kind))
    else $error("queued request dropped under stall");
endmodule

bind sce_socket_ctrl sce_socket_ctrl_sva #(.SOCKET_ID(SOCKET_ID)) u_sva (
  .clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid),
  .cmd_code(cmd_code), .cmd_ready(cmd_ready),
  .socket_protocol_mode(socket_protocol_mode),
  .socket_event_mask(socket_event_mask), .flags_wr(flags_wr),
  .flags_wdata(flags_wdata), .socket_event_flags_q(socket_event_flags_q),
  .global_socket_flag(global_socket_flag),
  .socket_state_q(socket_state_q), .rx_read_pointer(rx_read_pointer),
  .rx_consume_q(rx_consume_q), .rx_consumed_ptr_q(rx_consumed_ptr_q),
  .txq_valid(txq_valid), .txq_ready(txq_ready), .txq_kind(txq_kind),
  .ev_finack_rx(ev_finack_rx), .ev_rst_rx(ev_rst_rx),
  .ev_data_rx(ev_data_rx), .ev_timeout(ev_timeout)
);

/* File: testbench/socket_command_and_event_flags_tb.sv */
// Self-checking bench for the socket command and event block
module socket_command_and_event_flags_tb import sce_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic             clk_sys   = 1'b0;
  logic             rst       = 1'b1;
  logic             cmd_valid = 1'b0;
  logic [7:0]       cmd_code  = 8'h00;
  logic [3:0]       mode      = MODE_TCP;
  logic [7:0]       mask      = 8'hff;
  logic             flags_wr  = 1'b0;
  logic [7:0]       wdata     = 8'h00;
  logic [PTR_W-1:0] txr       = 16'h0010;
  logic [PTR_W-1:0] txw       = 16'h0040;
  logic [PTR_W-1:0] rxr       = 16'h0000;
  logic [9:0]       ev        = 10'h000;
  logic             stall     = 1'b0;
  wire logic             cmd_ready, ign, gflag, rxc, tv, tr;
  wire logic [7:0]       flags, state, klog;
  wire logic [3:0]       tk;
  wire logic [PTR_W-1:0] rxp, trp, twp, span;
  int                    err_total = 0;
  int                    n_tests   = 0;

  always #50 clk_sys = ~clk_sys;

  sce_socket_ctrl dut (
    .clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_ready(cmd_ready), .cmd_ignored_q(ign),
    .socket_protocol_mode(mode), .socket_event_mask(mask),
    .flags_wr(flags_wr), .flags_wdata(wdata),
    .socket_event_flags_q(flags), .global_socket_flag(gflag),
    .socket_state_q(state), .tx_read_pointer(txr),
    .tx_write_pointer(txw), .rx_read_pointer(rxr), .rx_consume_q(rxc),
    .rx_consumed_ptr_q(rxp), .txq_valid(tv), .txq_ready(tr),
    .txq_kind(tk), .txq_rd_ptr(trp), .txq_wr_ptr(twp),
    .ev_established(ev[0]), .ev_fin_rx(ev[1]), .ev_finack_rx(ev[2]),
    .ev_rst_rx(ev[3]), .ev_data_rx(ev[4]), .ev_timeout(ev[5]),
    .ev_send_done(ev[6]), .ev_ppp_unsup(ev[7]),
    .ev_ppp_auth_fail(ev[8]), .ev_ppp_phase(ev[9])
  );
  sce_drain_model u_eng (
    .clk_sys(clk_sys), .rst(rst), .stall(stall), .txq_valid(tv),
    .txq_kind(tk), .txq_rd_ptr(trp), .txq_wr_ptr(twp),
    .txq_ready(tr), .kind_log(klog), .span(span)
  );

  task automatic close_out();
    if (err_total == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmd(input logic [7:0] c, input bit hold = 1'b0);
    int i;
    if (!cmd_valid) @(negedge clk_sys);
    cmd_valid = 1'b1;
    cmd_code  = c;
    for (i = 0; i < 20 && cmd_ready !== 1'b1; i++) @(negedge clk_sys);
    if (i == 20) begin
      err_total++;
      close_out();
    end
    @(negedge clk_sys);
    if (!hold) cmd_valid = 1'b0;
  endtask
  task automatic pulse(input int b);
    @(negedge clk_sys);
    ev[b] = 1'b1;
    @(negedge clk_sys);
    ev[b] = 1'b0;
  endtask
  task automatic wr(input logic [7:0] d);
    flags_wr = 1'b1;
    wdata    = d;
    @(negedge clk_sys);
    flags_wr = 1'b0;
  endtask
  task automatic drain();
    int i;
    stall = 1'b0;
    for (i = 0; i < 20 && tv !== 1'b0; i++) @(negedge clk_sys);
    if (i == 20) begin
      err_total++;
      close_out();
    end
  endtask
  task automatic t_link();
    mode = MODE_TCP;
    cmd(CMD_OPEN);
    chk(state, SS_INIT);
    cmd(CMD_CONNECT);
    chk(state, SS_CONNECTING);
    pulse(0);
    chk({state, flags}, {SS_LINKED, 8'h01});
    wr(8'h01);
    chk({gflag, flags}, 9'h000);
  endtask
  task automatic t_send();
    t_link();
    stall = 1'b1;
    cmd(CMD_SEND_FHW);
    chk(ign, 1'b1);
    cmd(CMD_PPP_START);
    chk(ign, 1'b1);
    cmd(8'h7f);
    chk({ign, tv}, 2'b10);
    cmd(CMD_SEND, 1'b1);
    chk({tk, trp, twp}, {PK_DATA, txr, txw});
    cmd(CMD_KEEPALIVE, 1'b1);
    chk(cmd_ready, 1'b0);
    cmd_valid = 1'b0;
    drain();
    chk({klog, span}, {PK_DATA, PK_KEEPALIVE, 16'(KEEP_BYTES)});
  endtask
  task automatic t_events();
    mask = 8'hfb;
    pulse(4);
    chk(flags, 8'h00);
    mask = 8'hff;
    pulse(4);
    chk({gflag, flags}, 9'h104);
    wr(8'h00);
    chk(flags, 8'h04);
    pulse(6);
    pulse(7);
    chk(flags, 8'h14);
    rxr = 16'h1234;
    cmd(CMD_RECEIVE_DONE_COMMAND);
    chk({rxc, rxp}, {1'b1, rxr});
    pulse(1);
    chk(flags, 8'h16);
    wr(8'h16);
    chk({gflag, flags}, 9'h000);
  endtask
  task automatic t_teardown();
    stall = 1'b1;
    cmd(CMD_TEARDOWN);
    chk({state, tv, tk}, {SS_CLOSING, 1'b1, PK_FIN});
    pulse(2);
    chk(state, SS_RELEASED);
    drain();
    t_link();
    stall = 1'b1;
    cmd(CMD_TEARDOWN);
    chk({tv, tk}, {1'b1, PK_FIN});
    pulse(5);
    chk({flags, state}, {8'h08, SS_RELEASED});
    drain();
    wr(8'h08);
  endtask
  task automatic t_resets();
    cmd(CMD_OPEN);
    cmd(CMD_LISTEN);
    chk(state, SS_LISTEN);
    pulse(5);
    chk({flags, state}, {8'h08, SS_RELEASED});
    wr(8'h08);
    cmd(CMD_OPEN);
    cmd(CMD_CONNECT);
    pulse(3);
    chk(state, SS_RELEASED);
    t_link();
    pulse(3);
    chk(state, SS_RELEASED);
    cmd(CMD_OPEN);
    cmd(CMD_CLOSE);
    chk({state, tv}, {SS_RELEASED, 1'b0});
  endtask
  task automatic t_modes();
    logic [7:0] cs[5];
    logic [3:0] ks[5];
    cs = '{CMD_PPP_START, CMD_PPP_REQ, CMD_PPP_NAK, CMD_PPP_REJ,
           CMD_PPP_STOP};
    ks = '{PK_PPP_DISC, PK_PPP_REQ, PK_PPP_NAK, PK_PPP_REJ, PK_PPP_TERM};
    mode = MODE_IPRAW;
    cmd(CMD_OPEN);
    chk(state, SS_IPRAW);
    cmd(CMD_CLOSE);
    chk(state, SS_RELEASED);
    mode = MODE_UDP;
    cmd(CMD_OPEN);
    cmd(CMD_SEND_FHW);
    @(negedge clk_sys);
    chk({state, klog[3:0]}, {SS_UDP, PK_DATA_FHW});
    cmd(CMD_CLOSE);
    mode = MODE_PPPOE;
    cmd(CMD_OPEN);
    pulse(7);
    chk({state, flags}, {SS_PPPOE, 8'h80});
    wr(8'h80);
    for (int i = 0; i < 5; i++) begin
      cmd(cs[i]);
      @(negedge clk_sys);
      chk(klog[3:0], ks[i]);
    end
    chk(state, SS_RELEASED);
  endtask

  initial begin
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    chk({cmd_ready, tv, gflag, flags, state}, {3'b100, 16'h0000});
    t_send();
    t_events();
    t_teardown();
    t_resets();
    t_modes();
    close_out();
  end
endmodule
